// >>> rtl/adsp_top.v
// Host-facing digital logic of a six-channel converter front end:
// serial slave port, data-ready output, clock and reference selection.
// Assumes one core clock standing for the master clock, serial pins
// oversampled by it, and a user side that fills read bytes ahead of time.
//
// Notes on behaviour
// RULE1: ready pin driven high or floats
// RULE2: one low pulse per finished conversion
// RULE3: pulse half sample period, output rate
// RULE4: pulse independent of serial activity
// RULE5: chip select high ignores all traffic
// RULE6: frame from select fall to rise
// RULE7: hard reset blocks serial communication
// RULE8: sample rising edge, shift falling edge
// RULE9: modes 0,0 and 1,1 both work
// RULE10: serial clock asynchronous, only during frames
// RULE11: output floats outside read data phase
// RULE12: output driven only serving reads
// RULE13: host sends eight-bit command first
// RULE14: command decoded as read or write
// RULE15: input ignored after read command
// RULE16: external clock select bypasses crystal
// RULE17: crystal clock by default
// RULE18: reference select picks internal or external
// RULE19: internal reference selected by default
// RULE20: host keeps prescaled clock in range
// RULE21: prescale divides by 1, 2, 4, 8
// RULE22: sample clock is prescaled clock over four
// RULE23: output rate is sample clock over ratio
// RULE24: hard reset restores defaults, stops clocks; clock and reference selects still follow their inputs
// RULE25: select rise abandons partial transfer
// RULE26: ready pulse uses master clock only
`timescale 1ns/1ps
`include "adsp_defs.vh"
module adsp_top #(
  parameter DATA_W = `ADSP_CMD_BITS
) (
  input wire CORE_CLK_I,
  input wire RST_I,
  input wire HARD_RESET_N_I,
  input wire CS_N_I,
  input wire SCK_I,
  input wire SDI_I,
  output reg SDO_O,
  output reg SDO_OE_O,
  input wire READY_PIN_DRIVE_SELECT_I,
  output reg DATA_READY_N_O,
  output reg DATA_READY_OE_O,
  input wire EXTERNAL_CLOCK_SELECT_I,
  input wire EXTERNAL_REFERENCE_SELECT_I,
  input wire [`ADSP_PRE_W-1:0] ANALOG_CLOCK_PRESCALE_I,
  input wire [`ADSP_OSR_W-1:0] OVERSAMPLING_RATIO_I,
  output reg CRYSTAL_OSC_EN_O,
  output reg EXT_CLOCK_PASS_O,
  output reg INT_REFERENCE_EN_O,
  output reg REFERENCE_SWITCH_ON_O,
  output reg CLOCK_DIST_EN_O,
  output reg CONVERSION_DONE_O,
  output reg [DATA_W-1:0] CMD_DATA_O,
  output reg CMD_VALID_O,
  output reg [DATA_W-1:0] WR_DATA_O,
  output reg WR_VALID_O,
  output reg FRAME_ACTIVE_O,
  input wire [DATA_W-1:0] RD_DATA_I,
  input wire RD_VALID_I,
  output reg RD_READY_O
);

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  reg cs_s1_r;
  reg cs_s2_r;
  reg cs_s3_r;
  reg sck_s1_r;
  reg sck_s2_r;
  reg sck_s3_r;
  reg sdi_s1_r;
  reg sdi_s2_r;
  reg hrst_s1_r;
  reg hrst_s2_r;
  wire sck_rise;
  wire sck_fall;
  wire cs_rise;
  wire cs_low;
  wire port_on;

  // RULE10: serial clock synchronised
  // Serial pins are retimed into the core clock; the first stage feeds
  // the second only. Six core samples per 20 MHz period is the margin.
  always @(posedge CORE_CLK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      cs_s1_r <= 1'b1;
      cs_s2_r <= 1'b1;
      cs_s3_r <= 1'b1;
      sck_s1_r <= 1'b0;
      sck_s2_r <= 1'b0;
      sck_s3_r <= 1'b0;
      sdi_s1_r <= 1'b0;
      sdi_s2_r <= 1'b0;
      hrst_s1_r <= 1'b0;
      hrst_s2_r <= 1'b0;
    end
    else
    begin
      cs_s1_r <= CS_N_I;
      cs_s2_r <= cs_s1_r;
      cs_s3_r <= cs_s2_r;
      sck_s1_r <= SCK_I;
      sck_s2_r <= sck_s1_r;
      sck_s3_r <= sck_s2_r;
      sdi_s1_r <= SDI_I;
      sdi_s2_r <= sdi_s1_r;
      hrst_s1_r <= HARD_RESET_N_I;
      hrst_s2_r <= hrst_s1_r;
    end
  end

  // RULE8: edge use
  // Edges taken from the settled stages only; mode 0,0 and 1,1 differ
  // only in idle level, which edge detection does not care about.
  // RULE9: both clock modes
  assign sck_rise = sck_s2_r & ~sck_s3_r;
  assign sck_fall = ~sck_s2_r & sck_s3_r;
  assign cs_rise = cs_s2_r & ~cs_s3_r;
  assign cs_low = ~cs_s2_r;
  // RULE7: hard reset blocks port
  assign port_on = hrst_s2_r;

  // ****************************************************************
  // Read data buffer
  // ****************************************************************
  wire buf_in_ready;
  wire [DATA_W-1:0] buf_data;
  wire buf_valid;
  reg buf_pop;
  wire buf_push_req;
  wire buf_full_nxt;

  // Only a word offered while ready stands is taken, so accept and ready agree
  assign buf_push_req = RD_VALID_I & RD_READY_O;
  assign buf_full_nxt = ~buf_pop & (~buf_in_ready | (buf_valid & buf_push_req));

  adsp_buf2 #(
    .W(DATA_W)
  ) u_buf (
    .clk_i(CORE_CLK_I),
    .rst_i(RST_I),
    .clr_i(~port_on),
    .in_data_i(RD_DATA_I),
    .in_valid_i(buf_push_req),
    .in_ready_o(buf_in_ready),
    .out_data_o(buf_data),
    .out_valid_o(buf_valid),
    .out_ready_i(buf_pop)
  );

  // ****************************************************************
  // Serial state machine
  // ****************************************************************
  reg [3:0] state_r;
  reg [3:0] state_nxt;
  reg [`ADSP_BIT_CNT_W-1:0] bit_cnt_r;
  reg [`ADSP_BIT_CNT_W-1:0] bit_cnt_nxt;
  reg [DATA_W-1:0] shin_r;
  reg [DATA_W-1:0] shin_nxt;
  reg [DATA_W-1:0] shout_r;
  reg [DATA_W-1:0] shout_nxt;
  reg cmd_pulse;
  reg wr_pulse;
  reg out_load;
  wire byte_done;

  assign byte_done = sck_rise & (bit_cnt_r == {`ADSP_BIT_CNT_W{1'b1}});

  always @*
  begin
    state_nxt = state_r;
    bit_cnt_nxt = bit_cnt_r;
    shin_nxt = shin_r;
    shout_nxt = shout_r;
    cmd_pulse = 1'b0;
    wr_pulse = 1'b0;
    out_load = 1'b0;
    buf_pop = 1'b0;
    case (state_r)
      `ADSP_ST_IDLE:
      begin
        bit_cnt_nxt = {`ADSP_BIT_CNT_W{1'b0}};
        // RULE6: frame opens on select low
        if (cs_low)
          state_nxt = `ADSP_ST_CMD;
      end
      `ADSP_ST_CMD:
      begin
        // RULE13: first byte is command
        if (sck_rise)
        begin
          shin_nxt = {shin_r[DATA_W-2:0], sdi_s2_r};
          bit_cnt_nxt = bit_cnt_r + {{(`ADSP_BIT_CNT_W-1){1'b0}}, 1'b1};
        end
        if (byte_done)
        begin
          cmd_pulse = 1'b1;
          // RULE14: read or write split
          if (shin_nxt[`ADSP_CMD_RW_BIT] == `ADSP_CMD_READ)
            state_nxt = `ADSP_ST_READ;
          else
            state_nxt = `ADSP_ST_WRITE;
        end
      end
      `ADSP_ST_WRITE:
      begin
        if (sck_rise)
        begin
          shin_nxt = {shin_r[DATA_W-2:0], sdi_s2_r};
          bit_cnt_nxt = bit_cnt_r + {{(`ADSP_BIT_CNT_W-1){1'b0}}, 1'b1};
        end
        if (byte_done)
          wr_pulse = 1'b1;
      end
      `ADSP_ST_READ:
      begin
        // RULE15: input ignored while reading
        // Falling edges shift out; a new byte is fetched at bit zero.
        // An empty buffer sends the idle byte since the host cannot wait.
        if (sck_fall)
        begin
          out_load = 1'b1;
          bit_cnt_nxt = bit_cnt_r + {{(`ADSP_BIT_CNT_W-1){1'b0}}, 1'b1};
          if (bit_cnt_r == {`ADSP_BIT_CNT_W{1'b0}})
          begin
            buf_pop = buf_valid;
            shout_nxt = buf_valid ? buf_data : `ADSP_IDLE_BYTE;
          end
          else
            shout_nxt = {shout_r[DATA_W-2:0], 1'b0};
        end
      end
      default:
      begin
        state_nxt = `ADSP_ST_IDLE;
      end
    endcase
    // RULE25: select rise abandons transfer
    // RULE5: select high ignores traffic
    if (cs_rise | ~cs_low)
    begin
      state_nxt = `ADSP_ST_IDLE;
      cmd_pulse = 1'b0;
      wr_pulse = 1'b0;
      out_load = 1'b0;
      buf_pop = 1'b0;
    end
  end

  // State registers; hard reset returns everything to defaults
  // RULE24: hard reset restores defaults
  always @(posedge CORE_CLK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      state_r <= `ADSP_ST_IDLE;
      bit_cnt_r <= {`ADSP_BIT_CNT_W{1'b0}};
      shin_r <= {DATA_W{1'b0}};
      shout_r <= {DATA_W{1'b0}};
    end
    else if (!port_on)
    begin
      state_r <= `ADSP_ST_IDLE;
      bit_cnt_r <= {`ADSP_BIT_CNT_W{1'b0}};
      shin_r <= {DATA_W{1'b0}};
      shout_r <= {DATA_W{1'b0}};
    end
    else
    begin
      state_r <= state_nxt;
      bit_cnt_r <= bit_cnt_nxt;
      shin_r <= shin_nxt;
      shout_r <= shout_nxt;
    end
  end

  // ****************************************************************
  // Data-ready generator
  // ****************************************************************
  wire rdy_n;
  wire rdy_pulse;

  // RULE26: master clock only
  // RULE21: prescale code feeds divider
  // RULE22: divide by four
  // RULE23: divide by ratio
  adsp_rate_gen #(
    .CNT_W(`ADSP_RATE_CNT_W)
  ) u_rate (
    .clk_i(CORE_CLK_I),
    .rst_i(RST_I),
    .run_i(port_on),
    .pre_i(ANALOG_CLOCK_PRESCALE_I),
    .osr_i(OVERSAMPLING_RATIO_I),
    .ready_n_o(rdy_n),
    .pulse_o(rdy_pulse)
  );

  // ****************************************************************
  // Registered outputs
  // ****************************************************************
  // Every pin output comes from a flop; defaults hold under RST_I, while hard reset lets clock and reference selects follow their inputs
  always @(posedge CORE_CLK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      SDO_O <= 1'b0;
      SDO_OE_O <= 1'b0;
      DATA_READY_N_O <= 1'b1;
      DATA_READY_OE_O <= 1'b0;
      CRYSTAL_OSC_EN_O <= 1'b1;
      EXT_CLOCK_PASS_O <= 1'b0;
      INT_REFERENCE_EN_O <= 1'b1;
      REFERENCE_SWITCH_ON_O <= 1'b1;
      CLOCK_DIST_EN_O <= 1'b0;
      CONVERSION_DONE_O <= 1'b0;
      CMD_DATA_O <= {DATA_W{1'b0}};
      CMD_VALID_O <= 1'b0;
      WR_DATA_O <= {DATA_W{1'b0}};
      WR_VALID_O <= 1'b0;
      FRAME_ACTIVE_O <= 1'b0;
      RD_READY_O <= 1'b0;
    end
    else
    begin
      // RULE11: output floats unless reading
      // RULE12: drive only in read phase
      SDO_OE_O <= port_on & (state_nxt == `ADSP_ST_READ) & (state_r == `ADSP_ST_READ | cmd_pulse);
      if (out_load)
        SDO_O <= shout_nxt[DATA_W-1];
      // RULE1: drive or float idle
      // Floating mode drives only the low pulse; a pull-up holds it high
      DATA_READY_N_O <= rdy_n | ~port_on;
      DATA_READY_OE_O <= port_on & (READY_PIN_DRIVE_SELECT_I | ~rdy_n);
      CONVERSION_DONE_O <= rdy_pulse & port_on;
      // RULE16: external clock passes through
      // RULE17: crystal by default
      CRYSTAL_OSC_EN_O <= ~EXTERNAL_CLOCK_SELECT_I;
      EXT_CLOCK_PASS_O <= EXTERNAL_CLOCK_SELECT_I;
      // RULE18: reference source choice
      // RULE19: internal reference on zero
      INT_REFERENCE_EN_O <= ~EXTERNAL_REFERENCE_SELECT_I;
      REFERENCE_SWITCH_ON_O <= ~EXTERNAL_REFERENCE_SELECT_I;
      // RULE24: clocks stop in hard reset
      CLOCK_DIST_EN_O <= port_on;
      CMD_VALID_O <= port_on & cmd_pulse;
      if (cmd_pulse)
        CMD_DATA_O <= shin_nxt;
      WR_VALID_O <= port_on & wr_pulse;
      if (wr_pulse)
        WR_DATA_O <= shin_nxt;
      FRAME_ACTIVE_O <= port_on & (state_nxt != `ADSP_ST_IDLE);
      // Ready follows the buffer; it stalls the source when both are full
      RD_READY_O <= port_on & ~buf_full_nxt;
    end
  end

endmodule

// >>> rtl/adsp_defs.vh
// Constants for the converter host port: serial framing, command decode,
// clock division and timing figures.
// Assumes inclusion by bare name from the top and rate generator files of the block.
`ifndef ADSP_DEFS_VH
`define ADSP_DEFS_VH

// ****************************************************************
// Serial command framing
// ****************************************************************
`define ADSP_CMD_BITS 8
`define ADSP_BIT_CNT_W 3
`define ADSP_CMD_RW_BIT 0
`define ADSP_CMD_READ 1'b1
`define ADSP_IDLE_BYTE 8'h00

// ****************************************************************
// Serial state codes, one-hot
// ****************************************************************
`define ADSP_ST_IDLE 4'h1
`define ADSP_ST_CMD 4'h2
`define ADSP_ST_WRITE 4'h4
`define ADSP_ST_READ 4'h8

// ****************************************************************
// Clock division: sample clock is prescaled clock over four,
// oversampling ratio is 32 << code
// ****************************************************************
`define ADSP_PRE_W 2
`define ADSP_OSR_W 3
`define ADSP_DIV4_SHIFT 2
`define ADSP_OSR_BASE_SHIFT 5
`define ADSP_RATE_CNT_W 18
`define ADSP_PRE_RESET 2'h0

// ****************************************************************
// Timing figures
// ****************************************************************
`define ADSP_CORE_CLK_MHZ 125
`define ADSP_SCK_MAX_MHZ 20
// Core samples per fastest serial clock period, rounded down
`define ADSP_SCK_MIN_SAMPLES (`ADSP_CORE_CLK_MHZ / `ADSP_SCK_MAX_MHZ)

`endif

// >>> rtl/adsp_buf2.v
// Two-entry buffer between the read-data source and the serial shifter.
// Assumes one clock, and that the drain side pops only when valid.
`timescale 1ns/1ps
module adsp_buf2 #(
  parameter W = 8
) (
  input wire clk_i,
  input wire rst_i,
  input wire clr_i,
  input wire [W-1:0] in_data_i,
  input wire in_valid_i,
  output wire in_ready_o,
  output wire [W-1:0] out_data_o,
  output wire out_valid_o,
  input wire out_ready_i
);

  reg [W-1:0] mem_r [0:1];
  reg wr_ptr_r;
  reg rd_ptr_r;
  reg [1:0] count_r;
  reg not_full_r;
  wire push;
  wire pop;
  reg [1:0] count_nxt;

  assign push = in_valid_i & not_full_r;
  assign pop = out_ready_i & (count_r != 2'h0);
  assign in_ready_o = not_full_r;
  assign out_valid_o = (count_r != 2'h0);
  assign out_data_o = mem_r[rd_ptr_r];

  // Occupancy after this cycle
  always @*
  begin
    count_nxt = count_r;
    if (push & ~pop)
      count_nxt = count_r + 2'h1;
    else if (pop & ~push)
      count_nxt = count_r - 2'h1;
  end

  // Pointers and storage; full kept in a flop so ready is registered
  always @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      wr_ptr_r <= 1'b0;
      rd_ptr_r <= 1'b0;
      count_r <= 2'h0;
      not_full_r <= 1'b1;
      mem_r[0] <= {W{1'b0}};
      mem_r[1] <= {W{1'b0}};
    end
    else if (clr_i)
    begin
      wr_ptr_r <= 1'b0;
      rd_ptr_r <= 1'b0;
      count_r <= 2'h0;
      not_full_r <= 1'b1;
    end
    else
    begin
      if (push)
      begin
        mem_r[wr_ptr_r] <= in_data_i;
        wr_ptr_r <= ~wr_ptr_r;
      end
      if (pop)
        rd_ptr_r <= ~rd_ptr_r;
      count_r <= count_nxt;
      not_full_r <= (count_nxt != 2'h2);
    end
  end

endmodule

// >>> rtl/adsp_rate_gen.v
// Data-ready pulse generator, clocked by the master clock only.
// Assumes prescale and ratio codes are steady or change rarely; a change
// takes effect at once, since period and low time are decoded without a register.
`timescale 1ns/1ps
`include "adsp_defs.vh"
module adsp_rate_gen #(
  parameter CNT_W = `ADSP_RATE_CNT_W
) (
  input wire clk_i,
  input wire rst_i,
  input wire run_i,
  input wire [`ADSP_PRE_W-1:0] pre_i,
  input wire [`ADSP_OSR_W-1:0] osr_i,
  output reg ready_n_o,
  output reg pulse_o
);

  wire [4:0] period_shift;
  wire [CNT_W-1:0] period_m1;
  wire [CNT_W-1:0] low_width;
  reg [CNT_W-1:0] cnt_r;
  reg [CNT_W-1:0] cnt_nxt;

  // One output period is 4 x prescale x ratio master cycles
  assign period_shift = {3'h0, pre_i} + {2'h0, osr_i} + 5'd7;
  assign period_m1 = ({{(CNT_W-1){1'b0}}, 1'b1} << period_shift) - {{(CNT_W-1){1'b0}}, 1'b1};
  // Low time is half a sample clock period: 2 x prescale cycles
  assign low_width = {{(CNT_W-1){1'b0}}, 1'b1} << ({1'b0, pre_i} + 3'h1);

  always @*
  begin
    cnt_nxt = cnt_r + {{(CNT_W-1){1'b0}}, 1'b1};
    if (cnt_r >= period_m1)
      cnt_nxt = {CNT_W{1'b0}};
  end

  // RULE3: pulse from master clock
  // Low during the last half sample period of each output period,
  // so the first pulse marks the first finished conversion.
  // RULE4: no serial dependency
  always @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      cnt_r <= {CNT_W{1'b0}};
      ready_n_o <= 1'b1;
      pulse_o <= 1'b0;
    end
    else if (!run_i)
    begin
      cnt_r <= {CNT_W{1'b0}};
      ready_n_o <= 1'b1;
      pulse_o <= 1'b0;
    end
    else
    begin
      cnt_r <= cnt_nxt;
      // RULE2: one low pulse per conversion
      ready_n_o <= ~(cnt_nxt > (period_m1 - low_width));
      pulse_o <= (cnt_nxt == (period_m1 - low_width + {{(CNT_W-1){1'b0}}, 1'b1}));
    end
  end

endmodule

// >>> verification/adsp_top_asserts.sv
// Checker for the converter host port, bound to adsp_top.
// Assumes one core clock and RST_I as its only asynchronous reset.
`timescale 1ns/1ps
module adsp_chk #(
  parameter DATA_W = 8
) (
  input wire CORE_CLK_I,
  input wire RST_I,
  input wire HARD_RESET_N_I,
  input wire CS_N_I,
  input wire SDO_OE_O,
  input wire READY_PIN_DRIVE_SELECT_I,
  input wire DATA_READY_N_O,
  input wire DATA_READY_OE_O,
  input wire EXTERNAL_CLOCK_SELECT_I,
  input wire EXTERNAL_REFERENCE_SELECT_I,
  input wire CRYSTAL_OSC_EN_O,
  input wire EXT_CLOCK_PASS_O,
  input wire INT_REFERENCE_EN_O,
  input wire CLOCK_DIST_EN_O,
  input wire CONVERSION_DONE_O,
  input wire [DATA_W-1:0] CMD_DATA_O,
  input wire CMD_VALID_O,
  input wire WR_VALID_O
);
  default clocking @(posedge CORE_CLK_I); endclocking
  default disable iff (RST_I);
  // ****************************************************************
  // Serial side; windows allow for the pin synchronisers
  // ****************************************************************
  cmd_read_oe_a: assert property (CMD_VALID_O && CMD_DATA_O[0] |=> SDO_OE_O)
    else $error("read command did not enable serial output");
  write_float_a: assert property (CMD_VALID_O && !CMD_DATA_O[0] |=> !SDO_OE_O [*8])
    else $error("serial output driven in a write frame");
  oe_cause_a: assert property ($rose(SDO_OE_O) |-> CMD_VALID_O && CMD_DATA_O[0])
    else $error("serial output enabled without a read command");
  cs_high_float_a: assert property (CS_N_I [*6] |-> !SDO_OE_O)
    else $error("serial output driven while deselected");
  cs_high_quiet_a: assert property (CS_N_I [*6] |-> !CMD_VALID_O && !WR_VALID_O)
    else $error("byte accepted while deselected");
  hard_block_a: assert property (!HARD_RESET_N_I [*4] |-> !SDO_OE_O && !CMD_VALID_O && !CLOCK_DIST_EN_O)
    else $error("activity during hard reset");
  // ****************************************************************
  // Data ready pin and clock or reference selection
  // ****************************************************************
  done_pulse_a: assert property ($fell(DATA_READY_N_O) |-> CONVERSION_DONE_O ##1 !CONVERSION_DONE_O)
    else $error("conversion done not a single pulse at ready fall");
  ready_width_a: assert property (HARD_RESET_N_I [*3] ##0 $fell(DATA_READY_N_O) |=> !DATA_READY_N_O)
    else $error("ready pulse shorter than two cycles");
  ready_drive_a: assert property (!DATA_READY_N_O |-> DATA_READY_OE_O)
    else $error("ready low but not driven");
  ready_float_a: assert property (!READY_PIN_DRIVE_SELECT_I [*4] ##0 DATA_READY_N_O
    && $past(DATA_READY_N_O) |-> !DATA_READY_OE_O)
    else $error("ready pin driven high in float mode");
  clk_sel_a: assert property (HARD_RESET_N_I [*4] |-> EXT_CLOCK_PASS_O == $past(EXTERNAL_CLOCK_SELECT_I)
    && CRYSTAL_OSC_EN_O != EXT_CLOCK_PASS_O)
    else $error("clock source outputs wrong");
  ref_sel_a: assert property (HARD_RESET_N_I [*4] |-> INT_REFERENCE_EN_O == !$past(EXTERNAL_REFERENCE_SELECT_I))
    else $error("reference enable wrong");
endmodule

bind adsp_top adsp_chk #(.DATA_W(DATA_W)) u_chk (.CORE_CLK_I, .RST_I, .HARD_RESET_N_I, .CS_N_I, .SDO_OE_O,
  .READY_PIN_DRIVE_SELECT_I, .DATA_READY_N_O, .DATA_READY_OE_O, .EXTERNAL_CLOCK_SELECT_I,
  .EXTERNAL_REFERENCE_SELECT_I, .CRYSTAL_OSC_EN_O, .EXT_CLOCK_PASS_O, .INT_REFERENCE_EN_O,
  .CLOCK_DIST_EN_O, .CONVERSION_DONE_O, .CMD_DATA_O, .CMD_VALID_O, .WR_VALID_O);

// >>> verification/adsp_host.sv
// Host model: serial master framing bytes MSB first.
// Assumes the core clock paces it; half an SCK period is 8 core cycles.
`timescale 1ns/1ps
module adsp_host (
  input wire clk,
  input wire sdo,
  input wire sdo_oe,
  output logic cs_n,
  output logic sck,
  output logic sdi
);
  initial
  begin
    cs_n = 1'b1;
    sck = 1'b0;
    sdi = 1'b0;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // drive on fall, sample on rise
  task automatic xfer(input bit sel, input bit m11, input int nb, input logic [31:0] tx, output logic [31:0] rx);
    rx = '0;
    sck = m11;
    cyc(2);
    cs_n = !sel;
    cyc(8);
    for (int i = nb - 1; i >= 0; i--)
    begin
      sck = 1'b0;
      sdi = tx[i];
      cyc(8);
      sck = 1'b1;
      rx[i] = sdo_oe ? sdo : 1'bx;
      cyc(8);
    end
    sck = m11;
    cyc(8);
    cs_n = 1'b1;
    // Released line shows a stale inverted bit, not a held value
    sdi = ~sdi;
    cyc(8);
  endtask
endmodule

// >>> verification/tb_adsp_top.sv
// Self-checking bench for adsp_top with the host model on the serial pins.
// Assumes the design's defaults: read bit is command bit 0, empty buffer sends zero.
`timescale 1ns/1ps
module tb_adsp_top;
  logic clk, rst, hard_n, drv_sel, ext_clk, ext_ref, rd_valid;
  logic [1:0] pre;
  logic [2:0] oversampling_ratio;
  logic [7:0] rd_data, last_cmd, last_wr;
  logic [31:0] rx;
  wire cs_n, sck, sdi, sdo, sdo_oe, rdy_n, rdy_oe, xo, xp, ri, rs, cd, done, cmd_v, wr_v, rd_rdy, fa;
  wire [7:0] cmd_d, wr_d;
  int n_fail = 0, checked = 0, n_cmd = 0, n_wr = 0, oe_cnt = 0, cyc_cnt = 0, fa_cnt = 0, c0, w0, o0, f0, lo, hi;
  always #4 clk = ~clk;
  adsp_top u_dut (.CORE_CLK_I(clk), .RST_I(rst), .HARD_RESET_N_I(hard_n), .CS_N_I(cs_n), .SCK_I(sck),
    .SDI_I(sdi), .SDO_O(sdo), .SDO_OE_O(sdo_oe), .READY_PIN_DRIVE_SELECT_I(drv_sel), .DATA_READY_N_O(rdy_n),
    .DATA_READY_OE_O(rdy_oe), .EXTERNAL_CLOCK_SELECT_I(ext_clk), .EXTERNAL_REFERENCE_SELECT_I(ext_ref),
    .ANALOG_CLOCK_PRESCALE_I(pre), .OVERSAMPLING_RATIO_I(oversampling_ratio), .CRYSTAL_OSC_EN_O(xo), .EXT_CLOCK_PASS_O(xp),
    .INT_REFERENCE_EN_O(ri), .REFERENCE_SWITCH_ON_O(rs), .CLOCK_DIST_EN_O(cd), .CONVERSION_DONE_O(done),
    .CMD_DATA_O(cmd_d), .CMD_VALID_O(cmd_v), .WR_DATA_O(wr_d), .WR_VALID_O(wr_v), .FRAME_ACTIVE_O(fa),
    .RD_DATA_I(rd_data), .RD_VALID_I(rd_valid), .RD_READY_O(rd_rdy));
  adsp_host u_host (.clk(clk), .sdo(sdo), .sdo_oe(sdo_oe), .cs_n(cs_n), .sck(sck), .sdi(sdi));
  task automatic finish_test;
    if (n_fail == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  // Byte monitor and hang guard; falling edge sees settled outputs
  always @(negedge clk)
  begin
    if (fa === 1'b1)
      fa_cnt++;
    if (cmd_v === 1'b1)
    begin
      n_cmd++;
      last_cmd = cmd_d;
    end
    if (wr_v === 1'b1)
    begin
      n_wr++;
      last_wr = wr_d;
    end
    if (sdo_oe === 1'b1)
      oe_cnt++;
    cyc_cnt++;
    if (cyc_cnt == 60000)
    begin
      n_fail++;
      finish_test();
    end
  end
  task automatic mark;
    c0 = n_cmd;
    w0 = n_wr;
    o0 = oe_cnt;
    f0 = fa_cnt;
  endtask
  task automatic t_sel;
    for (int i = 0; i < 4; i++)
    begin
      {ext_ref, ext_clk} = i[1:0];
      u_host.cyc(2);
      chk("clk_pass", xp, i[0]);
      chk("xtal_en", xo, !i[0]);
      chk("ref_en", ri, !i[1]);
      chk("ref_sw", rs, !i[1]);
    end
    {ext_ref, ext_clk} = 2'h0;
  endtask
  task automatic t_write;
    mark();
    u_host.xfer(1, 0, 16, {16'h0, 8'h02, 8'ha5}, rx);
    chk("cmd_cnt", n_cmd - c0, 1);
    chk("cmd", last_cmd, 8'h02);
    chk("wr", last_wr, 8'ha5);
    chk("wr_oe", oe_cnt - o0, 0);
    chk("frame", fa_cnt > f0, 1);
  endtask
  task automatic push(input logic [7:0] d);
    rd_data = d;
    rd_valid = 1'b1;
    while (rd_rdy !== 1'b1) u_host.cyc(1);
    u_host.cyc(1);
    rd_valid = 1'b0;
  endtask
  task automatic t_read;
    push(8'h3c);
    push(8'hc3);
    u_host.cyc(1);
    chk("full", rd_rdy, 0);
    // Offer a third word while full; it must be refused
    rd_data = 8'h99;
    rd_valid = 1'b1;
    u_host.cyc(3);
    rd_valid = 1'b0;
    mark();
    u_host.xfer(1, 1, 32, {8'h01, 24'hffffff}, rx);
    chk("rd_data", rx[23:0], 24'h3cc300);
    chk("rd_no_wr", n_wr - w0, 0);
    chk("empty", rd_rdy, 1);
  endtask
  task automatic t_abort;
    mark();
    u_host.xfer(1, 0, 5, 32'h1f, rx);
    mark();
    u_host.xfer(0, 0, 16, 32'h0881, rx);
    chk("desel", n_cmd - c0, 0);
    chk("desel_frame", fa_cnt - f0, 0);
    u_host.xfer(1, 0, 16, 32'h045a, rx);
    chk("restart", last_cmd, 8'h04);
    chk("restart_wr", last_wr, 8'h5a);
  endtask
  task automatic t_hard;
    mark();
    hard_n = 1'b0;
    u_host.cyc(4);
    u_host.xfer(1, 0, 16, 32'h0677, rx);
    chk("hr_cmd", n_cmd - c0, 0);
    chk("hr_dist", cd, 0);
    chk("hr_rdy", rdy_n, 1);
    hard_n = 1'b1;
    u_host.cyc(6);
    chk("dist", cd, 1);
  endtask
  task automatic t_ready;
    for (int i = 0; i < 5; i++)
    begin
      pre = (i < 4) ? i[1:0] : 2'h0;
      oversampling_ratio = (i < 4) ? 3'h0 : 3'h2;
      drv_sel = i[0];
      repeat (2)
      begin
        while (rdy_n !== 1'b0) u_host.cyc(1);
        while (rdy_n !== 1'b1) u_host.cyc(1);
      end
      chk("rdy_oe", rdy_oe, drv_sel);
      hi = 0;
      lo = 0;
      while (rdy_n !== 1'b0)
      begin
        hi++;
        u_host.cyc(1);
      end
      while (rdy_n === 1'b0)
      begin
        lo++;
        u_host.cyc(1);
      end
      chk("rdy_low", lo, 2 << pre);
      chk("rdy_per", lo + hi, 4 * (1 << pre) * (32 << oversampling_ratio));
    end
  endtask
  initial
  begin
    clk = 1'b0;
    rst = 1'b1;
    hard_n = 1'b1;
    drv_sel = 1'b0;
    ext_clk = 1'b0;
    ext_ref = 1'b0;
    rd_valid = 1'b0;
    pre = 2'h0;
    oversampling_ratio = 3'h0;
    rd_data = 8'h00;
    repeat (6) @(posedge clk);
    #1;
    rst = 1'b0;
    u_host.cyc(2);
    chk("xtal_def", xo, 1);
    chk("ref_def", ri, 1);
    chk("rdy_oe_def", rdy_oe, 0);
    t_sel();
    t_write();
    t_read();
    t_abort();
    t_hard();
    t_ready();
    finish_test();
  end
endmodule
